// [rtl/slps_consts.vh]
// Constants for the serial link power and startup controller
`ifndef SLPS_CONSTS_VH
`define SLPS_CONSTS_VH

// Register indices (byte address is four times the index)
`define SLPS_IDX_SAWTOOTH_DIVIDER 6'h03
`define SLPS_IDX_CTRL 6'h04
`define SLPS_IDX_STAT 6'h05
`define SLPS_IDX_PROT 6'h06

// Control register fields
`define SLPS_CTRL_SLEEP 0
`define SLPS_CTRL_VIDEO 1
`define SLPS_CTRL_CFG 2
`define SLPS_CTRL_SS_LO 3
`define SLPS_CTRL_SS_HI 5
`define SLPS_CTRL_LANE4 6

// Reset values
`define SLPS_SAWTOOTH_DIVIDER_RST 6'h3F
`define SLPS_SS_OFF 3'h0
`define SLPS_SS_HALF 3'h1
`define SLPS_PROT_RST 32'h00000000

// Spread coefficients, four lanes then three lanes
`define SLPS_COEF4_LOW 8'h68
`define SLPS_COEF4_MID 8'h98
`define SLPS_COEF4_HIGH 8'hCC
`define SLPS_COEF3_LOW 8'h50
`define SLPS_COEF3_MID 8'h70
`define SLPS_COEF3_HIGH 8'h98

// Timing counts in clock cycles, except pixel lock which counts pixel clock edges
`define SLPS_PCLK_LOCK_EDGES 8'h40
`define SLPS_PCLK_GAP_CYC 8'h10
`define SLPS_OSC_LOCK_CYC 8'h80
`define SLPS_WAKE_CYC 8'h20

`endif

// [rtl/slps_top.v]
// Power state, link startup and spread sawtooth control of a serializer
// Summary of operation
// - Modulation rate follows pixel clock, coefficient, divider
// - Four-lane coefficients 104, 152, 204
// - Three-lane coefficients 80, 112, 152
// - Writing sleep bit sleeps at once
// - Sleep clears protection registers, keeps configuration
// - Shutdown pin low: shutdown, outputs released
// - Shutdown entry restores software register defaults, latched straps keep their values
// - Leaving shutdown relatches strap input levels
// - Config link enable starts oscillator-clocked link
// - Video link enable overrides config link
// - Control channel ready only after link up
// - Startup select low: autostart video link
// - Startup select high: standby until enabled
// - Send wake-up after locking
// - Autostart wakes a sleeping far side
// - Divider held in bits 5:0 at index 3
`timescale 1ns/100ps
`default_nettype none
`include "slps_consts.vh"

module slps_top (
    input wire CLK,
    input wire RESET,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [7:0] PADDR,
    input wire [31:0] PWDATA,
    output reg [31:0] PRDATA,
    output wire PREADY,
    output wire PSLVERR,
    input wire SHUTDOWN_N,
    input wire RATE_SELECT_PIN,
    input wire SPREAD_AT_POWER_UP,
    input wire STARTUP_SELECT_N,
    input wire [1:0] BUS_ID,
    input wire PIXEL_CLOCK_IN,
    output reg SERIAL_TX_EN,
    output wire SERIAL_TX_OE,
    output reg WAKEUP_TX,
    output reg OSC_CLOCK_SEL,
    output reg CTRL_CHAN_READY,
    output reg SLEEP_ACTIVE,
    output reg [15:0] SS_RAMP,
    output reg SS_PERIOD_TICK
);

    // Link states
    localparam ST_STANDBY = 3'h0;
    localparam ST_LOCK = 3'h1;
    localparam ST_WAKE = 3'h2;
    localparam ST_UP = 3'h3;
    localparam ST_SLEEP = 3'h4;

    reg sd_s1_q, sd_s2_q;
    reg drs_s1_q, drs_s2_q;
    reg spread_at_power_up_s1_q, spread_at_power_up_s2_q;
    reg startup_select_n_s1_q, startup_select_n_s2_q;
    reg [1:0] bid_s1_q, bid_s2_q, bus_id_q;
    reg pck_s1_q, pck_s2_q, pck_prev_q;
    reg strap_pend_q, drs_q, startup_select_n_q;
    reg sleep_q, video_q, cfg_q, lane4_q;
    reg [2:0] ss_q, state_q, state_d;
    reg [5:0] sawtooth_divider_q;
    reg [31:0] prot_q;
    reg [7:0] cnt_q, cnt_d, gap_q, coef;
    reg link_video_q, link_video_d;
    reg [15:0] ramp_q;
    wire dev_off, pck_edge, pck_alive, wr_en, word_ok;
    wire hit_sawtooth_divider, hit_ctrl, hit_stat, hit_prot;
    wire [15:0] period, step;
    wire want_video, want_cfg;

    // Two-stage synchronisers for pins
    always @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            sd_s1_q <= 1'b0;
            sd_s2_q <= 1'b0;
            drs_s1_q <= 1'b0;
            drs_s2_q <= 1'b0;
            spread_at_power_up_s1_q <= 1'b0;
            spread_at_power_up_s2_q <= 1'b0;
            startup_select_n_s1_q <= 1'b0;
            startup_select_n_s2_q <= 1'b0;
            bid_s1_q <= 2'h0;
            bid_s2_q <= 2'h0;
            pck_s1_q <= 1'b0;
            pck_s2_q <= 1'b0;
        end else begin
            sd_s1_q <= SHUTDOWN_N;
            sd_s2_q <= sd_s1_q;
            drs_s1_q <= RATE_SELECT_PIN;
            drs_s2_q <= drs_s1_q;
            spread_at_power_up_s1_q <= SPREAD_AT_POWER_UP;
            spread_at_power_up_s2_q <= spread_at_power_up_s1_q;
            startup_select_n_s1_q <= STARTUP_SELECT_N;
            startup_select_n_s2_q <= startup_select_n_s1_q;
            bid_s1_q <= BUS_ID;
            bid_s2_q <= bid_s1_q;
            pck_s1_q <= PIXEL_CLOCK_IN;
            pck_s2_q <= pck_s1_q;
        end
    end

    assign dev_off = ~sd_s2_q;
    assign pck_edge = pck_s2_q & ~pck_prev_q;
    assign pck_alive = (gap_q != 8'h00);

    // Pixel clock edge and activity tracking
    always @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            pck_prev_q <= 1'b0;
            gap_q <= 8'h00;
        end else begin
            pck_prev_q <= pck_s2_q;
            if (pck_edge) begin
                gap_q <= `SLPS_PCLK_GAP_CYC;
            end else if (gap_q != 8'h00) begin
                gap_q <= gap_q - 8'h01;
            end
        end
    end

    // APB decode, zero wait states
    assign PREADY = 1'b1;
    assign word_ok = (PADDR[1:0] == 2'h0);
    assign hit_sawtooth_divider = word_ok & (PADDR[7:2] == `SLPS_IDX_SAWTOOTH_DIVIDER);
    assign hit_ctrl = word_ok & (PADDR[7:2] == `SLPS_IDX_CTRL);
    assign hit_stat = word_ok & (PADDR[7:2] == `SLPS_IDX_STAT);
    assign hit_prot = word_ok & (PADDR[7:2] == `SLPS_IDX_PROT);
    assign PSLVERR = PSEL & PENABLE & ~(hit_sawtooth_divider | hit_ctrl | hit_stat | hit_prot);
    assign wr_en = PSEL & PENABLE & PWRITE & ~dev_off;

    // Straps and software registers; shutdown holds the software registers at defaults, straps keep their values
    always @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            strap_pend_q <= 1'b1;
            drs_q <= 1'b0;
            startup_select_n_q <= 1'b1;
            bus_id_q <= 2'h0;
            sleep_q <= 1'b0;
            video_q <= 1'b0;
            cfg_q <= 1'b0;
            lane4_q <= 1'b0;
            ss_q <= `SLPS_SS_OFF;
            sawtooth_divider_q <= `SLPS_SAWTOOTH_DIVIDER_RST;
            prot_q <= `SLPS_PROT_RST;
        end else if (dev_off) begin
            strap_pend_q <= 1'b1;
            sleep_q <= 1'b0;
            video_q <= 1'b0;
            cfg_q <= 1'b0;
            lane4_q <= 1'b0;
            ss_q <= `SLPS_SS_OFF;
            sawtooth_divider_q <= `SLPS_SAWTOOTH_DIVIDER_RST;
            prot_q <= `SLPS_PROT_RST;
        end else if (strap_pend_q) begin
            // Latch straps on leaving reset or shutdown
            strap_pend_q <= 1'b0;
            drs_q <= drs_s2_q;
            startup_select_n_q <= startup_select_n_s2_q;
            bus_id_q <= bid_s2_q;
            ss_q <= spread_at_power_up_s2_q ? `SLPS_SS_HALF : `SLPS_SS_OFF;
            video_q <= ~startup_select_n_s2_q;
        end else begin
            if (wr_en && hit_ctrl) begin
                sleep_q <= PWDATA[`SLPS_CTRL_SLEEP];
                video_q <= PWDATA[`SLPS_CTRL_VIDEO];
                cfg_q <= PWDATA[`SLPS_CTRL_CFG];
                ss_q <= PWDATA[`SLPS_CTRL_SS_HI:`SLPS_CTRL_SS_LO];
                lane4_q <= PWDATA[`SLPS_CTRL_LANE4];
            end
            if (wr_en && hit_sawtooth_divider) begin
                sawtooth_divider_q <= PWDATA[5:0];
            end
            if (wr_en && hit_ctrl && PWDATA[`SLPS_CTRL_SLEEP]) begin
                prot_q <= `SLPS_PROT_RST;
            end else if (wr_en && hit_prot) begin
                prot_q <= PWDATA;
            end
        end
    end

    // Read data mux
    always @* begin
        PRDATA = 32'h00000000;
        if (hit_sawtooth_divider) begin
            PRDATA[5:0] = sawtooth_divider_q;
        end else if (hit_ctrl) begin
            PRDATA[6:0] = {lane4_q, ss_q, cfg_q, video_q, sleep_q};
        end else if (hit_stat) begin
            PRDATA[9:0] = {bus_id_q, startup_select_n_q, drs_q, link_video_q, pck_alive,
                           CTRL_CHAN_READY, state_q};
        end else if (hit_prot) begin
            PRDATA = prot_q;
        end
    end

    // Video wins over the config link
    assign want_video = video_q;
    assign want_cfg = cfg_q & ~video_q;

    // Link startup state machine
    always @* begin
        state_d = state_q;
        cnt_d = cnt_q;
        link_video_d = link_video_q;
        case (state_q)
            ST_STANDBY: begin
                // Standby sends nothing until enabled
                cnt_d = 8'h00;
                if (sleep_q) begin
                    state_d = ST_SLEEP;
                end else if (want_video || want_cfg) begin
                    state_d = ST_LOCK;
                    link_video_d = want_video;
                end
            end
            ST_LOCK: begin
                if (sleep_q) begin
                    state_d = ST_SLEEP;
                end else if (!want_video && !want_cfg) begin
                    state_d = ST_STANDBY;
                end else if (want_video != link_video_q) begin
                    state_d = ST_LOCK;
                    link_video_d = want_video;
                    cnt_d = 8'h00;
                end else if (link_video_q) begin
                    // Count pixel edges while the clock stays alive
                    if (!pck_alive) begin
                        cnt_d = 8'h00;
                    end else if (pck_edge) begin
                        cnt_d = cnt_q + 8'h01;
                    end
                    if (cnt_q == `SLPS_PCLK_LOCK_EDGES) begin
                        state_d = ST_WAKE;
                        cnt_d = 8'h00;
                    end
                end else begin
                    cnt_d = cnt_q + 8'h01;
                    if (cnt_q == `SLPS_OSC_LOCK_CYC) begin
                        state_d = ST_WAKE;
                        cnt_d = 8'h00;
                    end
                end
            end
            ST_WAKE: begin
                // Wake-up burst toward the far side
                cnt_d = cnt_q + 8'h01;
                if (sleep_q) begin
                    state_d = ST_SLEEP;
                end else if (cnt_q == `SLPS_WAKE_CYC) begin
                    state_d = ST_UP;
                    cnt_d = 8'h00;
                end
            end
            ST_UP: begin
                cnt_d = 8'h00;
                if (sleep_q) begin
                    state_d = ST_SLEEP;
                end else if (!want_video && !want_cfg) begin
                    state_d = ST_STANDBY;
                end else if (want_video != link_video_q) begin
                    state_d = ST_LOCK;
                    link_video_d = want_video;
                end else if (link_video_q && !pck_alive) begin
                    state_d = ST_LOCK;
                end
            end
            ST_SLEEP: begin
                cnt_d = 8'h00;
                if (!sleep_q) begin
                    state_d = ST_STANDBY;
                end
            end
            default: begin
                state_d = ST_STANDBY;
                cnt_d = 8'h00;
            end
        endcase
    end

    // State registers, cleared while shut down
    always @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            state_q <= ST_STANDBY;
            cnt_q <= 8'h00;
            link_video_q <= 1'b0;
        end else if (dev_off || strap_pend_q) begin
            state_q <= ST_STANDBY;
            cnt_q <= 8'h00;
            link_video_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            link_video_q <= link_video_d;
        end
    end

    // Registered link outputs
    always @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            SERIAL_TX_EN <= 1'b0;
            WAKEUP_TX <= 1'b0;
            OSC_CLOCK_SEL <= 1'b0;
            CTRL_CHAN_READY <= 1'b0;
            SLEEP_ACTIVE <= 1'b0;
        end else begin
            SERIAL_TX_EN <= ~dev_off & ((state_d == ST_WAKE) | (state_d == ST_UP));
            WAKEUP_TX <= ~dev_off & (state_d == ST_WAKE);
            OSC_CLOCK_SEL <= ~dev_off & (state_d != ST_STANDBY) & (state_d != ST_SLEEP)
                             & ~link_video_d;
            CTRL_CHAN_READY <= ~dev_off & (state_d == ST_UP);
            SLEEP_ACTIVE <= ~dev_off & sleep_q;
        end
    end

    // Outputs float while shut down
    assign SERIAL_TX_OE = sd_s2_q;

    // Spread coefficient by lane mode and spread select
    always @* begin
        case ({lane4_q, ss_q})
            4'h1, 4'h5: coef = `SLPS_COEF3_LOW;
            4'h2, 4'h6: coef = `SLPS_COEF3_MID;
            4'h3, 4'h7: coef = `SLPS_COEF3_HIGH;
            4'h9, 4'hD: coef = `SLPS_COEF4_LOW;
            4'hA, 4'hE: coef = `SLPS_COEF4_MID;
            4'hB, 4'hF: coef = `SLPS_COEF4_HIGH;
            default: coef = 8'h00;
        endcase
    end

    // Period is coefficient times divider; rate pin doubles the step
    assign period = {8'h00, coef} * {10'h000, sawtooth_divider_q};
    assign step = drs_q ? 16'h0002 : 16'h0001;

    // Sawtooth ramp, one step per pixel clock edge
    always @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            ramp_q <= 16'h0000;
            SS_RAMP <= 16'h0000;
            SS_PERIOD_TICK <= 1'b0;
        end else begin
            SS_PERIOD_TICK <= 1'b0;
            if (dev_off || coef == 8'h00 || sawtooth_divider_q == 6'h00 || !SERIAL_TX_EN) begin
                ramp_q <= 16'h0000;
            end else if (pck_edge) begin
                if (ramp_q + step >= period) begin
                    ramp_q <= 16'h0000;
                    SS_PERIOD_TICK <= 1'b1;
                end else begin
                    ramp_q <= ramp_q + step;
                end
            end
            SS_RAMP <= ramp_q;
        end
    end

endmodule // slps_top
`default_nettype wire

// [tb/slps_props.sv]
// Checker of power state and link startup behaviour
`timescale 1ns/100ps
`default_nettype none
module slps_props (
    input wire CLK,
    input wire RESET,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [7:0] PADDR,
    input wire [31:0] PWDATA,
    input wire SHUTDOWN_N,
    input wire SERIAL_TX_EN,
    input wire SERIAL_TX_OE,
    input wire WAKEUP_TX,
    input wire OSC_CLOCK_SEL,
    input wire CTRL_CHAN_READY,
    input wire SLEEP_ACTIVE,
    input wire [15:0] SS_RAMP
);
    logic [7:0] wake_q;
    wire ctl_wr = PSEL && PENABLE && PWRITE && PADDR == 8'h10 && SERIAL_TX_OE;
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);
    // Counts the cycles of the wake-up burst
    always @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            wake_q <= 8'h00;
        end else begin
            wake_q <= WAKEUP_TX ? wake_q + 8'h01 : 8'h00;
        end
    end
    chk_sleep_now: assert property (ctl_wr && PWDATA[0] |=> ##1 SLEEP_ACTIVE)
        else $error("sleep not entered");
    chk_sleep_quiet: assert property (ctl_wr && PWDATA[0] |=> ##1 !SERIAL_TX_EN && !CTRL_CHAN_READY)
        else $error("link kept running in sleep");
    chk_off_hiz: assert property (!SHUTDOWN_N [*3] |-> !SERIAL_TX_OE ##1 !SERIAL_TX_EN)
        else $error("outputs driven in shutdown");
    chk_off_defaults: assert property (!SHUTDOWN_N [*4] |-> !SLEEP_ACTIVE ##1 SS_RAMP == 16'h0000)
        else $error("state kept in shutdown");
    chk_cfg_lock: assert property ($rose(OSC_CLOCK_SEL) |-> ##[128:130] (WAKEUP_TX || !OSC_CLOCK_SEL || SLEEP_ACTIVE))
        else $error("oscillator link lock time wrong");
    chk_video_wins: assert property (ctl_wr && PWDATA[1] |=> ##1 !OSC_CLOCK_SEL)
        else $error("config link not overridden");
    chk_ready_late: assert property ($rose(CTRL_CHAN_READY) |-> $past(WAKEUP_TX) && SERIAL_TX_EN)
        else $error("channel ready before link up");
    chk_wake_len: assert property ($fell(WAKEUP_TX) && CTRL_CHAN_READY |-> wake_q == 8'h21)
        else $error("wake-up burst length wrong");
    cov_cfg_up: cover property (OSC_CLOCK_SEL && CTRL_CHAN_READY);
    cov_video_up: cover property (!OSC_CLOCK_SEL && CTRL_CHAN_READY);
    cov_sleep: cover property ($rose(SLEEP_ACTIVE));
endmodule // slps_props
bind slps_top slps_props u_props (.CLK(CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .SHUTDOWN_N(SHUTDOWN_N),
    .SERIAL_TX_EN(SERIAL_TX_EN), .SERIAL_TX_OE(SERIAL_TX_OE), .WAKEUP_TX(WAKEUP_TX),
    .OSC_CLOCK_SEL(OSC_CLOCK_SEL), .CTRL_CHAN_READY(CTRL_CHAN_READY),
    .SLEEP_ACTIVE(SLEEP_ACTIVE), .SS_RAMP(SS_RAMP));
`default_nettype wire

// [tb/slps_far.sv]
// Pixel clock source and remote receiver model
`timescale 1ns/100ps
`default_nettype none
module slps_far #(parameter int DIV = 4, parameter int WAIT_MAX = 800) (
    input wire logic clk,
    input wire logic pix_on,
    input wire logic tx_en,
    input wire logic wake,
    output logic pix,
    output logic asleep
);
    int n = 0;
    int t = 0;
    initial pix = 1'b0;
    initial asleep = 1'b1; // Starts asleep
    // Pixel clock, stands still when off
    always @(posedge clk) begin
        n <= (n == DIV - 1) ? 0 : n + 1;
        if (!pix_on) begin
            pix <= 1'b0;
        end else if (n == DIV - 1) begin
            pix <= !pix;
        end
    end
    // Wakes on the burst, locks on serial data or gives up
    always @(posedge clk) begin
        if (wake && asleep) begin // Awake receiver ignores the burst
            t <= 1;
        end else if (t != 0) begin
            t <= t + 1;
        end
        if (t != 0 && tx_en && !wake) begin
            asleep <= 1'b0;
            t <= 0;
        end else if (t >= WAIT_MAX) begin
            t <= 0; // Back to sleep
        end
    end
endmodule // slps_far
`default_nettype wire

// [tb/testbench.sv]
// Self-checking bench of the power and link startup controller
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, x) begin num_checks++; if ((g) !== (x)) begin err_total++; $display("ERROR %0t got %0h exp %0h", $time, g, x); end end
module testbench;
    logic clk, reset, psel, penable, pwrite, shutdown_n, rate_sel, startup_n, pix_on, e;
    logic spread_at_power_up;
    logic [1:0] bid;
    logic [7:0] paddr;
    logic [31:0] pwdata, q;
    wire [31:0] prdata;
    wire pready, pslverr, pix, asleep, tx_en, tx_oe, wake, osc, ready, sleeping, tick;
    int err_total = 0;
    int num_checks = 0;
    int c;
    int coef[6] = '{80, 112, 152, 104, 152, 204};
    slps_top u_dut (.CLK(clk), .RESET(reset), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .SHUTDOWN_N(shutdown_n), .RATE_SELECT_PIN(rate_sel), .SPREAD_AT_POWER_UP(spread_at_power_up),
        .STARTUP_SELECT_N(startup_n), .BUS_ID(bid), .PIXEL_CLOCK_IN(pix),
        .SERIAL_TX_EN(tx_en), .SERIAL_TX_OE(tx_oe), .WAKEUP_TX(wake), .OSC_CLOCK_SEL(osc),
        .CTRL_CHAN_READY(ready), .SLEEP_ACTIVE(sleeping), .SS_RAMP(), .SS_PERIOD_TICK(tick));
    slps_far u_far (.clk(clk), .pix_on(pix_on), .tx_en(tx_en), .wake(wake), .pix(pix),
        .asleep(asleep));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // One APB transfer from the host on this side, waits for ready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        logic rdy;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(negedge clk);
            rdy = pready;
            q = prdata;
            e = pslverr;
            @(posedge clk);
        end while (rdy !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h00000000);
        `CHK(q, x)
    endtask
    task automatic wait_up;
        repeat (3) @(posedge clk);
        c = 0;
        while (ready !== 1'b1 && c < 5000) begin
            @(negedge clk);
            c++;
        end
        `CHK(ready, 1'b1)
    endtask
    // Cycles between two sawtooth wraps
    task automatic gap(input int x);
        c = 0;
        while (tick !== 1'b1 && c < 9000) begin
            @(negedge clk);
            c++;
        end
        c = 0;
        do begin
            @(negedge clk);
            c++;
        end while (tick !== 1'b1 && c < 9000);
        `CHK(c, x)
    endtask
    task automatic t_defaults;
        repeat (20) @(posedge clk);
        @(negedge clk);
        `CHK(tx_en, 1'b0)
        rd(8'h0C, 32'h0000003F);
        rd(8'h10, 32'h00000008);
        rd(8'h14, 32'h00000280);
        rd(8'h40, 32'h00000000);
        `CHK(e, 1'b1)
    endtask
    task automatic t_cfg;
        apb(1'b1, 8'h10, 32'h00000004);
        wait_up;
        `CHK(osc, 1'b1)
        rd(8'h14, 32'h0000028B);
        `CHK(asleep, 1'b0)
        apb(1'b1, 8'h0C, 32'h0000002A);
        rd(8'h0C, 32'h0000002A);
    endtask
    task automatic t_video;
        @(posedge clk);
        pix_on <= 1'b1;
        apb(1'b1, 8'h10, 32'h00000006);
        wait_up;
        `CHK(osc, 1'b0)
        rd(8'h14, 32'h000002BB);
        apb(1'b1, 8'h0C, 32'h00000002);
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, 8'h10, 32'h2 | ((i % 3 + 1 + (i / 3) * 4) << 3) | ((i / 3) << 6));
            gap(16 * coef[i]);
        end
    endtask
    task automatic t_shutdown;
        @(posedge clk);
        shutdown_n <= 1'b0;
        rate_sel <= 1'b1;
        startup_n <= 1'b0;
        spread_at_power_up <= 1'b0;
        bid <= 2'h1;
        repeat (5) @(posedge clk);
        @(negedge clk);
        `CHK(tx_oe, 1'b0)
        `CHK(tx_en, 1'b0)
        @(posedge clk);
        shutdown_n <= 1'b1;
        wait_up;
        rd(8'h14, 32'h0000017B);
        rd(8'h0C, 32'h0000003F);
        rd(8'h10, 32'h00000002);
        apb(1'b1, 8'h10, 32'h0000000A);
        apb(1'b1, 8'h0C, 32'h00000002);
        gap(640);
    endtask
    task automatic t_sleep;
        apb(1'b1, 8'h18, 32'h12345678);
        rd(8'h18, 32'h12345678);
        apb(1'b1, 8'h10, 32'h0000000B);
        repeat (2) @(posedge clk);
        @(negedge clk);
        `CHK(sleeping, 1'b1)
        `CHK(tx_en, 1'b0)
        rd(8'h18, 32'h00000000);
        rd(8'h0C, 32'h00000002);
    endtask
    task automatic print_verdict;
        if (err_total == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        reset = 1'b1;
        {psel, penable, pwrite, rate_sel, pix_on} = 5'h00;
        {shutdown_n, startup_n} = 2'h3;
        {spread_at_power_up, bid} = 3'h6;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        repeat (3) @(posedge clk);
        t_defaults;
        t_cfg;
        t_video;
        t_shutdown;
        t_sleep;
        print_verdict;
    end
    // Watchdog
    initial begin
        repeat (80000) @(posedge clk);
        err_total++;
        print_verdict;
    end
endmodule // testbench
`default_nettype wire
